// ==== hfp_device_end.sv ====
module hfp_device_end (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    // host link
    hfp_link_if.dev          link,
    // buffer and fifo state from the switch core
    input  wire logic        rxbuf_free_in,
    input  wire logic        buf1_full_in,
    input  wire logic        buf2_full_in,
    input  wire logic        outbound_fifo_has_data_in,
    input  wire logic        inbound_fifo_has_room_in,
    input  wire logic        outbound_fifo_frame_end_in,
    // interrupt events from the switch core
    input  wire logic        frame_evt_in,
    input  wire logic        timeout_evt_in,
    // data offered to the host
    input  wire logic [15:0] buf1_data_in,
    input  wire logic [15:0] buf2_data_in,
    input  wire logic [15:0] frame_data_in,
    // command pulses to the core
    output logic [5:0]       cmd_pulse_out,
    // control command receive and transmit buffers
    output logic             cmdbuf_wr_out,
    output logic [15:0]      cmdbuf_wdata_out,
    output logic             buf1_rd_out,
    output logic             buf2_rd_out,
    // switch frame stream
    output logic             frame_wr_out,
    output logic             frame_rd_out,
    output logic [15:0]      frame_wdata_out,
    output logic             frame_eof_out,
    output logic             frame_hdr_out,
    output logic             frame_wide_out
);
    import hfp_pkg::*;

    logic [5:0]  cmd_q;
    logic        eof_armed_q;
    logic [7:0]  int_q;
    logic        buf1_full_q;
    logic        buf2_full_q;
    logic [15:0] in_pos_q;
    logic [15:0] out_pos_q;
    logic [15:0] step;
    logic        wr_cmd;
    logic        wr_int;
    logic        wr_frame;
    logic        rd_frame;
    logic [7:0]  status;

    assign wr_cmd   = link.wr && link.addr == ADDR_CMD;
    assign wr_int   = link.wr && link.addr == ADDR_INT;
    assign wr_frame = link.wr && link.addr == ADDR_FRAME;
    assign rd_frame = link.rd && link.addr == ADDR_FRAME;
    assign step     = link.wide ? 16'h0002 : 16'h0001;

    // command bits live one cycle, so the core sees a clean pulse
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
            cmd_q <= CMD_RESET;
        else if (wr_cmd)
            cmd_q <= link.wdata[5:0]; // RL1 RL2 RL3 RL4 RL5 RL6
        else
            cmd_q <= CMD_RESET; // RL1 RL2 RL3 RL4 RL6
    end
    assign cmd_pulse_out = cmd_q;

    // eof arming waits for the next inbound frame write
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
            eof_armed_q <= 1'b0;
        else if (wr_cmd && link.wdata[CMD_IN_EOF])
            eof_armed_q <= 1'b1; // RL5
        else if (wr_frame || (wr_cmd && link.wdata[CMD_REALIGN]))
            eof_armed_q <= 1'b0; // RL5 RL6
    end

    // previous levels for buffer edge detection
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            buf1_full_q <= 1'b0;
            buf2_full_q <= 1'b0;
        end
        else
        begin
            buf1_full_q <= buf1_full_in;
            buf2_full_q <= buf2_full_in;
        end
    end

    // sticky sources; a new event beats a clear in the same cycle
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
            int_q <= INT_RESET;
        else
        begin
            int_q <= (wr_int ? (int_q & link.wdata[7:0]) : int_q) & INT_USED_MASK; // RL16
            if (frame_evt_in)
                int_q[INT_FRAME] <= 1'b1; // RL14
            if (buf1_full_in && !buf1_full_q)
                int_q[INT_BUF1] <= 1'b1; // RL14
            if (buf2_full_in && !buf2_full_q)
                int_q[INT_BUF2] <= 1'b1; // RL14
            if (timeout_evt_in)
                int_q[INT_TIMEOUT] <= 1'b1; // RL15
        end
    end

    // pin follows the register with one cycle of delay
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
            link.irq <= 1'b0;
        else
            link.irq <= |(int_q & INT_USED_MASK); // RL21
    end

    // live status; reserved bits read as zero
    always_comb
    begin
        status = 8'h00;
        status[0] = rxbuf_free_in; // RL8
        status[1] = buf1_full_in; // RL9
        status[2] = buf2_full_in; // RL10
        status[3] = outbound_fifo_has_data_in; // RL11
        status[4] = inbound_fifo_has_room_in; // RL12
        status[5] = outbound_fifo_frame_end_in; // RL13
    end

    // read answer one cycle after the strobe
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            link.rdata  <= 16'h0000;
            link.rvalid <= 1'b0;
        end
        else
        begin
            link.rvalid <= link.rd;
            case (link.addr)
                ADDR_FRAME: link.rdata <= frame_data_in;
                ADDR_CMD:   link.rdata <= {8'h00, status};
                ADDR_INT:   link.rdata <= {8'h00, int_q};
                ADDR_BUF1:  link.rdata <= buf1_data_in; // RL18
                ADDR_BUF2:  link.rdata <= buf2_data_in; // RL19
                default:    link.rdata <= 16'h0000;
            endcase
        end
    end

    // buffer strobes; a write to address 7 is simply dropped
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            cmdbuf_wr_out    <= 1'b0;
            cmdbuf_wdata_out <= 16'h0000;
            buf1_rd_out      <= 1'b0;
            buf2_rd_out      <= 1'b0;
        end
        else
        begin
            cmdbuf_wr_out <= link.wr && link.addr == ADDR_BUF1; // RL17
            if (link.wr && link.addr == ADDR_BUF1)
                cmdbuf_wdata_out <= link.wide ? link.wdata : {8'h00, link.wdata[7:0]};
            buf1_rd_out <= link.rd && link.addr == ADDR_BUF1; // RL18
            buf2_rd_out <= link.rd && link.addr == ADDR_BUF2; // RL19
        end
    end

    // byte positions inside the current frame, each direction alone
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            in_pos_q  <= 16'h0000;
            out_pos_q <= 16'h0000;
        end
        else
        begin
            if ((wr_frame && eof_armed_q) || (wr_cmd && link.wdata[CMD_REALIGN]))
                in_pos_q <= 16'h0000; // RL5 RL6
            else if (wr_frame)
                in_pos_q <= in_pos_q + step; // RL20
            if (wr_cmd && link.wdata[CMD_OUT_DONE])
                out_pos_q <= 16'h0000; // RL4
            else if (rd_frame)
                out_pos_q <= out_pos_q + step; // RL20
        end
    end

    // frame stream toward the core, marked header or data
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            frame_wr_out    <= 1'b0;
            frame_rd_out    <= 1'b0;
            frame_wdata_out <= 16'h0000;
            frame_eof_out   <= 1'b0;
            frame_hdr_out   <= 1'b0;
            frame_wide_out  <= 1'b0;
        end
        else
        begin
            frame_wr_out <= wr_frame;
            frame_rd_out <= rd_frame;
            if (wr_frame || rd_frame)
            begin
                frame_wdata_out <= link.wdata;
                frame_wide_out  <= link.wide;
                frame_eof_out   <= wr_frame && eof_armed_q; // RL5
                frame_hdr_out   <= wr_frame ? (in_pos_q < FRAME_HDR_BYTES)
                                            : (out_pos_q < FRAME_HDR_BYTES); // RL20
            end
        end
    end
endmodule // hfp_device_end

// ==== hfp_pkg.sv ====
// Behaviour
// RL1 - cmd bit0 marks receive buffer full, self-clears
// RL2 - cmd bit1 releases transmit buffer one
// RL3 - cmd bit2 releases transmit buffer two
// RL4 - cmd bit3 marks outbound frame taken
// RL5 - cmd bit4 flags next inbound write EOF
// RL6 - cmd bit5 restarts inbound data alignment
// RL7 - host writes zeros to command bits 7:6
// RL8 - status bit0: receive buffer accepts command
// RL9 - status bit1: buffer one holds command
// RL10 - status bit2: buffer two holds command
// RL11 - status bit3: outbound fifo has data
// RL12 - status bit4: inbound fifo has room
// RL13 - status bit5: outbound frame end; 7:6 reserved
// RL14 - interrupt reg: frame, buffer1, buffer2 sources
// RL15 - interrupt bit7 set on device timeout
// RL16 - timeout bit cleared only by writing 0
// RL17 - writes to address 6 append receive buffer
// RL18 - reads from address 6 drain buffer one
// RL19 - address 7 read-only, drains buffer two
// RL20 - frames: eight-byte header, then data
// RL21 - interrupt pin follows any set source
package hfp_pkg;
    // link addresses of the directly reached registers
    localparam logic [3:0] ADDR_FRAME = 4'h3;
    localparam logic [3:0] ADDR_CMD   = 4'h4;
    localparam logic [3:0] ADDR_INT   = 4'h5;
    localparam logic [3:0] ADDR_BUF1  = 4'h6;
    localparam logic [3:0] ADDR_BUF2  = 4'h7;
    // command bit positions
    localparam int CMD_RXBUF_FULL = 0;
    localparam int CMD_BUF1_FREE  = 1;
    localparam int CMD_BUF2_FREE  = 2;
    localparam int CMD_OUT_DONE   = 3;
    localparam int CMD_IN_EOF     = 4;
    localparam int CMD_REALIGN    = 5;
    localparam logic [7:0] CMD_RSVD_MASK = 8'hc0;
    // interrupt bit positions and writable sources
    localparam int INT_FRAME   = 0;
    localparam int INT_BUF1    = 1;
    localparam int INT_BUF2    = 2;
    localparam int INT_TIMEOUT = 7;
    localparam logic [7:0] INT_USED_MASK = 8'h87;
    localparam logic [7:0] INT_RESET     = 8'h00;
    localparam logic [5:0] CMD_RESET     = 6'h00;
    // frame header length in bytes
    localparam logic [15:0] FRAME_HDR_BYTES = 16'h0008;
    // host controller registers on the axi4-lite side
    localparam logic [3:0] AXI_ACCESS = 4'h0;
    localparam logic [3:0] AXI_RESULT = 4'h4;
    localparam int ACC_ADDR_LSB = 0;
    localparam int ACC_READ     = 8;
    localparam int ACC_WIDE     = 9;
    localparam int ACC_DATA_LSB = 16;
    localparam int RES_BUSY     = 16;
    localparam int RES_IRQ      = 17;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum {HFP_IDLE, HFP_WAIT} hfp_state_type;
endpackage

// ==== hfp_link_if.sv ====
interface hfp_link_if;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        wide;
    logic [15:0] rdata;
    logic        rvalid;
    logic        irq;
    modport dev (input addr, wdata, wr, rd, wide, output rdata, rvalid, irq);
    modport host (output addr, wdata, wr, rd, wide, input rdata, rvalid, irq);
endinterface

// ==== hfp_host_end.sv ====
module hfp_host_end (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    // axi4-lite write address and data
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // device link
    hfp_link_if.host         link
);
    import hfp_pkg::*;

    hfp_state_type state_q;
    logic [3:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic        aw_got_q;
    logic        w_got_q;
    logic [15:0] result_q;
    logic        do_wr;
    logic        start;
    logic        wstrb_any_q;

    assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;
    // a start while busy is dropped; software polls the busy bit
    // byte lanes are held from the w handshake, since wstrb is only valid with wvalid
    assign start = do_wr && awaddr_q == AXI_ACCESS && wstrb_any_q
                   && state_q == HFP_IDLE;

    // address and data are taken independently, answered together
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            awaddr_q      <= 4'h0;
            wdata_q       <= 32'h00000000;
            wstrb_any_q   <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_got_q && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_got_q && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_any_q <= |s_axi_wstrb;
            end
            if (do_wr)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_q == AXI_ACCESS || awaddr_q == AXI_RESULT)
                                ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
            end
        end
    end

    // read side: one cycle to accept, answer on the next
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                case (s_axi_araddr)
                    AXI_ACCESS: s_axi_rdata <= wdata_q;
                    AXI_RESULT: s_axi_rdata <= {14'h0000, link.irq,
                                                state_q != HFP_IDLE, result_q};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // link master: one strobe per access, reads wait for the answer
    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            state_q     <= HFP_IDLE;
            link.addr   <= 4'h0;
            link.wdata  <= 16'h0000;
            link.wr     <= 1'b0;
            link.rd     <= 1'b0;
            link.wide   <= 1'b0;
            result_q    <= 16'h0000;
        end
        else
        begin
            link.wr <= 1'b0;
            link.rd <= 1'b0;
            case (state_q)
                HFP_IDLE:
                    if (start)
                    begin
                        link.addr  <= wdata_q[ACC_ADDR_LSB +: 4];
                        link.wide  <= wdata_q[ACC_WIDE];
                        link.wdata <= wdata_q[ACC_DATA_LSB +: 16];
                        if (wdata_q[ACC_ADDR_LSB +: 4] == ADDR_CMD)
                            link.wdata <= wdata_q[ACC_DATA_LSB +: 16]
                                          & ~{8'h00, CMD_RSVD_MASK}; // RL7
                        if (wdata_q[ACC_READ])
                        begin
                            link.rd <= 1'b1;
                            state_q <= HFP_WAIT;
                        end
                        else
                            link.wr <= 1'b1;
                    end
                HFP_WAIT:
                    if (link.rvalid)
                    begin
                        result_q <= link.rdata;
                        state_q  <= HFP_IDLE;
                    end
                default: state_q <= HFP_IDLE;
            endcase
        end
    end
endmodule // hfp_host_end

// ==== hfp_link_monitor.sv ====
module hfp_link_monitor (
    // clock and reset
    input wire logic        mclk_in,
    input wire logic        reset_n_in,
    // link from host end
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic        wide,
    // link from device end
    input wire logic [15:0] rdata,
    input wire logic        rvalid,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import hfp_pkg::*;

    // one clock domain, so one clocking and one reset gate serve all checks
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);

    // read answer and its pacing
    rd_answer_a: assert property (rd |=> rvalid)
        else $error("link read not answered one cycle later");
    read_cause_a: assert property (rvalid |-> $past(rd))
        else $error("link answer without a read");
    rvalid_pulse_a: assert property (rvalid |=> !rvalid)
        else $error("link answer held longer than one cycle");
    host_waits_a: assert property (rd |=> !rd && !wr)
        else $error("host end issued a request before the answer");
    one_strobe_a: assert property (wr |-> !rd ##1 !wr)
        else $error("link strobes overlap or stretch");
    // reserved fields on the wire
    cmd_rsvd_a: assert property (wr && addr == ADDR_CMD |-> wdata[7:6] == 2'b00)
        else $error("reserved command bits written as one");
    status_rsvd_a: assert property (rd && addr == ADDR_CMD |=> rdata[7:6] == 2'b00)
        else $error("reserved status bits read as one");
    int_rsvd_a: assert property (rd && addr == ADDR_INT |=> rdata[6:3] == 4'h0)
        else $error("reserved interrupt bits read as one");
    // the pin lags the register by one cycle, exactly as the read does
    irq_follow_a: assert property (rd && addr == ADDR_INT |=> irq == (|rdata[7:0]))
        else $error("interrupt pin disagrees with interrupt register");

    // main traffic seen
    cover property (wr && addr == ADDR_CMD);
    cover property (rd && addr == ADDR_INT ##1 irq);
    cover property (wr && addr == ADDR_FRAME);
endmodule // hfp_link_monitor

// ==== tb.sv ====
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import hfp_pkg::*;
    // clock, reset and axi master signals
    logic        mclk_in = 0, reset_n_in = 0;
    logic [3:0]  awa = 0, ara = 0, wst = 4'hf;
    logic [31:0] wd = 0, rdat, res;
    logic        awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic        awr, wrd, bv, arr, rv;
    logic [1:0]  bresp, rresp;
    // core side of the device end
    logic [5:0]  st = 0, cmdp, lcmd;
    logic [15:0] b1d = 0, b2d = 0, cbd, lcbd, fdd = 0, fwd, lwd;
    logic        frd, fwide, lwide;
    int          nfr = 0;
    logic        fev = 0, tmo = 0, cbw, b1r, b2r, fw, hdr, eof, lhdr, leof;
    int          mismatches = 0, n_tests = 0, ncmd = 0, ncbw = 0, nb1 = 0, nb2 = 0;

    hfp_link_if link();
    hfp_device_end i_hfp_device_end (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .link(link),
        .rxbuf_free_in(st[0]), .buf1_full_in(st[1]), .buf2_full_in(st[2]),
        .outbound_fifo_has_data_in(st[3]), .inbound_fifo_has_room_in(st[4]),
        .outbound_fifo_frame_end_in(st[5]), .frame_evt_in(fev), .timeout_evt_in(tmo),
        .buf1_data_in(b1d), .buf2_data_in(b2d), .frame_data_in(fdd),
        .cmd_pulse_out(cmdp), .cmdbuf_wr_out(cbw), .cmdbuf_wdata_out(cbd),
        .buf1_rd_out(b1r), .buf2_rd_out(b2r), .frame_wr_out(fw), .frame_rd_out(frd),
        .frame_wdata_out(fwd), .frame_eof_out(eof), .frame_hdr_out(hdr),
        .frame_wide_out(fwide));
    hfp_host_end i_hfp_host_end (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .link(link));
    hfp_link_monitor i_hfp_link_monitor (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .addr(link.addr), .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .wide(link.wide),
        .rdata(link.rdata), .rvalid(link.rvalid), .irq(link.irq));

    // 25 mhz
    always #20 mclk_in = ~mclk_in;

    // core pulses last one cycle, so they are latched and counted here
    always @(posedge mclk_in)
    begin
        if (|cmdp)
        begin
            lcmd <= cmdp;
            ncmd <= ncmd + 1;
        end
        if (cbw)
        begin
            lcbd <= cbd;
            ncbw <= ncbw + 1;
        end
        if (b1r) nb1 <= nb1 + 1;
        if (b2r) nb2 <= nb2 + 1;
        if (fw || frd)
        begin
            lhdr  <= hdr;
            leof  <= eof;
            lwd   <= fwd;
            lwide <= fwide;
        end
        if (frd) nfr <= nfr + 1;
    end

    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic test_done;
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one axi4-lite transfer; each channel drops valid at its own handshake edge
    task automatic axi(input logic rd, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic [1:0] r);
        int k;
        bit done;
        done = 0;
        // let an edge pass so a ready lowered by the last call is not raised in the same step
        @(posedge mclk_in);
        if (rd)
        begin
            ara <= a;
            arv <= 1;
            rre <= 1;
        end
        else
        begin
            awa <= a;
            wd  <= d;
            awv <= 1;
            wv  <= 1;
            bre <= 1;
        end
        for (k = 0; k < 200 && !done; k++)
        begin
            @(posedge mclk_in);
            if (awv && awr) awv <= 0;
            if (wv && wrd) wv <= 0;
            if (arv && arr) arv <= 0;
            if (bv && bre)
            begin
                r = bresp;
                bre <= 0;
                done = 1;
            end
            if (rv && rre)
            begin
                q = rdat;
                r = rresp;
                rre <= 0;
                done = 1;
            end
        end
        if (!done)
        begin
            mismatches++;
            test_done;
        end
    endtask

    // one link access through the access register, then poll until idle
    task automatic lnk(input logic rd, input logic [3:0] a, input logic [15:0] d,
                       input logic w, output logic [15:0] q);
        int k;
        logic [1:0] r;
        logic [31:0] x;
        axi(0, AXI_ACCESS, {d, 6'h00, w, rd, 4'h0, a}, x, r);
        for (k = 0; k < 50; k++)
        begin
            axi(1, AXI_RESULT, 32'h0, res, r);
            if (res[RES_BUSY] === 1'b0) break;
        end
        if (k == 50)
        begin
            mismatches++;
            test_done;
        end
        q = res[15:0];
    endtask

    initial
    begin
        logic [31:0] q;
        logic [15:0] d;
        logic [1:0] r;
        int i, n;
        repeat (6) @(posedge mclk_in);
        reset_n_in <= 1;
        @(posedge mclk_in);
        axi(1, AXI_RESULT, 32'h0, q, r);
        `CHK("result_reset", 32'h0, q);
        axi(1, 4'h8, 32'h0, q, r);
        `CHK("rresp_unmapped", RESP_SLVERR, r);
        axi(0, 4'hc, 32'h1, q, r);
        `CHK("bresp_unmapped", RESP_SLVERR, r);
        // each command bit alone, reserved bits offered as one
        for (i = 0; i < 6; i++)
        begin
            n = ncmd;
            lnk(0, ADDR_CMD, 16'h00c0 | (16'h0001 << i), 0, d);
            `CHK("cmd_bit", 6'h01 << i, lcmd);
            `CHK("cmd_count", n + 1, ncmd);
            `CHK("cmd_selfclear", 6'h00, cmdp);
        end
        // status bits in two complementary patterns
        for (i = 0; i < 2; i++)
        begin
            st <= i ? 6'h15 : 6'h2a;
            lnk(1, ADDR_CMD, 16'h0000, 0, d);
            `CHK("status", {2'b00, st}, d[7:0]);
        end
        st <= 6'h00;
        // buffer ports, including a refused write to the read-only port
        b1d <= 16'h1234;
        b2d <= 16'hbeef;
        n = nb1;
        lnk(1, ADDR_BUF1, 16'h0000, 1, d);
        `CHK("buf1_data", 16'h1234, d);
        `CHK("buf1_pop", n + 1, nb1);
        n = nb2;
        lnk(1, ADDR_BUF2, 16'h0000, 1, d);
        `CHK("buf2_data", 16'hbeef, d);
        `CHK("buf2_pop", n + 1, nb2);
        n = ncbw;
        lnk(0, ADDR_BUF2, 16'h5555, 1, d);
        lnk(0, ADDR_BUF1, 16'ha5c3, 1, d);
        `CHK("rxbuf_writes", n + 1, ncbw);
        `CHK("rxbuf_wide", 16'ha5c3, lcbd);
        lnk(0, ADDR_BUF1, 16'h12ab, 0, d);
        `CHK("rxbuf_narrow", 16'h00ab, lcbd);
        // interrupt sources, sticky timeout, clear by writing zero
        lnk(0, ADDR_INT, 16'h0000, 0, d);
        st <= 6'h06;
        tmo <= 1;
        fev <= 1;
        @(posedge mclk_in);
        tmo <= 0;
        fev <= 0;
        lnk(1, ADDR_INT, 16'h0000, 0, d);
        `CHK("int_sources", 8'h87, d[7:0]);
        `CHK("irq_set", 1'b1, res[RES_IRQ]);
        lnk(1, ADDR_INT, 16'h0000, 0, d);
        `CHK("int_sticky", 8'h87, d[7:0]);
        lnk(0, ADDR_INT, 16'h007f, 0, d);
        lnk(1, ADDR_INT, 16'h0000, 0, d);
        `CHK("int_tmo_clear", 8'h07, d[7:0]);
        lnk(0, ADDR_INT, 16'h0000, 0, d);
        lnk(1, ADDR_INT, 16'h0000, 0, d);
        `CHK("int_clear", 8'h00, d[7:0]);
        `CHK("irq_clear", 1'b0, res[RES_IRQ]);
        // frame header span after realign, then an armed end of frame
        lnk(0, ADDR_CMD, 16'h0020, 0, d);
        for (i = 0; i < 5; i++)
        begin
            lnk(0, ADDR_FRAME, 16'(i), 1, d);
            `CHK("frame_hdr", i < 4, lhdr);
            `CHK("frame_wdata", i, lwd);
            `CHK("frame_wide", 1'b1, lwide);
        end
        lnk(0, ADDR_CMD, 16'h0010, 0, d);
        lnk(0, ADDR_FRAME, 16'h0001, 1, d);
        `CHK("frame_eof", 1'b1, leof);
        lnk(0, ADDR_FRAME, 16'h0002, 1, d);
        `CHK("frame_eof_once", 1'b0, leof);
        `CHK("frame_restart", 1'b1, lhdr);
        // outbound frame reads: header span, then restart once the frame is done
        for (i = 0; i < 5; i++)
        begin
            fdd <= 16'hc0d0 | 16'(i);
            n = nfr;
            lnk(1, ADDR_FRAME, 16'h0000, 1, d);
            `CHK("out_data", 16'hc0d0 | 16'(i), d);
            `CHK("out_pop", n + 1, nfr);
            `CHK("out_hdr", i < 4, lhdr);
        end
        lnk(0, ADDR_CMD, 16'h0008, 0, d);
        lnk(1, ADDR_FRAME, 16'h0000, 0, d);
        `CHK("out_restart", 1'b1, lhdr);
        `CHK("out_narrow", 1'b0, lwide);
        test_done;
    end
endmodule // tb
